// ---- hdl/bsp_top.sv ----
// boost solenoid pwm output stage, top level
// -------------------------------------------------------------
// -------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "bsp_regs.svh"
module bsp_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [15:0] output_period_setting,
  input wire logic timebase_range_scaler,
  input wire logic [1:0] solenoid_output_select,
  input wire bsp_pkg::bsp_duty_t duty_ceiling,
  input wire bsp_pkg::bsp_duty_t duty_floor,
  input wire logic [4:0] rpm_index,
  input wire logic [4:0] load_index,
  input wire logic map_wr_en,
  input wire bsp_pkg::bsp_addr_t map_wr_addr,
  input wire bsp_pkg::bsp_duty_t map_wr_data,
  input wire bsp_pkg::bsp_duty_t duty_low_target,
  input wire bsp_pkg::bsp_duty_t duty_high_target,
  input wire logic use_target_switch,
  input wire logic target_switch_pin,
  output logic output_pin_five_oe,
  output logic output_pin_six_oe,
  output logic output_pin_seven_oe,
  output logic output_pin_eight_oe,
  output logic output_pin_five,
  output logic output_pin_six,
  output logic output_pin_seven,
  output logic output_pin_eight,
  output bsp_pkg::bsp_duty_t duty_applied,
  output logic period_start
);
  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  function automatic bsp_pkg::bsp_duty_t clamp_duty(
    input bsp_pkg::bsp_duty_t d,
    input bsp_pkg::bsp_duty_t lo,
    input bsp_pkg::bsp_duty_t hi
  );
    bsp_pkg::bsp_duty_t r;
    r = d;
    if (r > hi) begin
      r = hi;
    end
    if (r < lo) begin
      r = lo;
    end
    if (r > `BSP_DUTY_FULL) begin
      r = `BSP_DUTY_FULL;
    end
    return r;
  endfunction

  // cycles per timebase tick: 200 for 1 us, 125 for the scaled tick
  localparam logic [7:0] TICK_NORMAL =
    8'(`BSP_TICK_NS_NORMAL / `BSP_CLK_NS);
  localparam logic [7:0] TICK_SCALED =
    8'(`BSP_TICK_NS_SCALED / `BSP_CLK_NS);

  // -----------------------------------------------------------
  // switch synchroniser
  // -----------------------------------------------------------
  logic sw_meta_r;
  logic sw_sync_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
    end else if (ce) begin
      sw_meta_r <= target_switch_pin;
      sw_sync_r <= sw_meta_r;
    end
  end

  // -----------------------------------------------------------
  // power-up capture of pin, period and scaler
  // -----------------------------------------------------------
  // settings are taken once after reset release; later changes
  // need a reset, so the pin never moves under a live solenoid
  logic cfg_done_r;
  logic [15:0] period_r;
  logic scaled_r;
  logic [1:0] pin_sel_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_done_r <= 1'b0;
      period_r <= 16'(`BSP_PERIOD_US_DEFAULT);
      scaled_r <= 1'b0;
      pin_sel_r <= 2'h2;
    end else if (ce && !cfg_done_r) begin
      cfg_done_r <= 1'b1;
      period_r <= output_period_setting;
      scaled_r <= timebase_range_scaler;
      pin_sel_r <= solenoid_output_select;
    end
  end

  // -----------------------------------------------------------
  // map lookup
  // -----------------------------------------------------------
  bsp_pkg::bsp_addr_t rd_addr;
  bsp_pkg::bsp_duty_t map_duty;
  logic [4:0] rpm_c;
  logic [4:0] load_c;
  always_comb begin
    rpm_c = (rpm_index > 5'(`BSP_MAP_COLS - 1)) ?
      5'(`BSP_MAP_COLS - 1) : rpm_index;
    load_c = (load_index > 5'(`BSP_MAP_ROWS - 1)) ?
      5'(`BSP_MAP_ROWS - 1) : load_index;
    rd_addr = 9'(load_c * `BSP_MAP_COLS + rpm_c);
  end

  bsp_map_mem u_map (
    .clk_sys(clk_sys),
    .ce(ce),
    .wr_en(map_wr_en),
    .wr_addr(map_wr_addr),
    .wr_data(map_wr_data),
    .rd_addr(rd_addr),
    .rd_data(map_duty)
  );

  // -----------------------------------------------------------
  // command selection and clamp
  // -----------------------------------------------------------
  bsp_pkg::bsp_duty_t cmd;
  bsp_pkg::bsp_duty_t cmd_clamped;
  always_comb begin
    if (use_target_switch) begin
      cmd = sw_sync_r ? duty_high_target : duty_low_target;
    end else begin
      cmd = map_duty;
    end
    cmd_clamped = clamp_duty(cmd, duty_floor, duty_ceiling);
  end

  // -----------------------------------------------------------
  // timebase tick
  // -----------------------------------------------------------
  logic [7:0] pre_r;
  logic tick;
  assign tick = (pre_r == 8'h00);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_r <= 8'h00;
    end else if (ce && cfg_done_r) begin
      if (tick) begin
        pre_r <= (scaled_r ? TICK_SCALED : TICK_NORMAL) - 8'h01;
      end else begin
        pre_r <= pre_r - 8'h01;
      end
    end
  end

  // -----------------------------------------------------------
  // period counter and duty latch
  // -----------------------------------------------------------
  // low time in ticks = period * duty / 1000, taken at boundary
  logic [15:0] cnt_r;
  logic [15:0] low_ticks_r;
  logic [25:0] prod;
  logic boundary;
  assign prod = 26'(period_r * cmd_clamped);
  assign boundary = tick && (cnt_r == 16'h0000);
  bsp_pkg::bsp_state_t st_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
    end else if (ce && cfg_done_r && tick) begin
      if (cnt_r == 16'h0000) begin
        cnt_r <= (period_r == 16'h0000) ? 16'h0000 :
          period_r - 16'h0001;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_ticks_r <= 16'h0000;
      duty_applied <= 10'h000;
    end else if (ce && cfg_done_r && boundary) begin
      low_ticks_r <= 16'(prod / 26'd1000);
      duty_applied <= cmd_clamped;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      period_start <= 1'b0;
    end else if (ce) begin
      period_start <= cfg_done_r && boundary;
    end
  end

  // elapsed ticks into the period decide the phase
  logic [15:0] elapsed;
  assign elapsed = 16'(period_r - 16'h0001 - cnt_r);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= bsp_pkg::BSP_ST_IDLE;
    end else if (ce) begin
      case (st_r)
        bsp_pkg::BSP_ST_IDLE: begin
          if (cfg_done_r && boundary) begin
            st_r <= bsp_pkg::BSP_ST_HIGH;
          end
        end
        bsp_pkg::BSP_ST_LOW, bsp_pkg::BSP_ST_HIGH: begin
          if (elapsed < low_ticks_r) begin
            st_r <= bsp_pkg::BSP_ST_LOW;
          end else begin
            st_r <= bsp_pkg::BSP_ST_HIGH;
          end
        end
        default: begin
          st_r <= bsp_pkg::BSP_ST_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------
  // pin drivers: open drain, only the selected pin ever sinks
  // -----------------------------------------------------------
  logic sink;
  assign sink = (st_r == bsp_pkg::BSP_ST_LOW);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      output_pin_five_oe <= 1'b0;
      output_pin_six_oe <= 1'b0;
      output_pin_seven_oe <= 1'b0;
      output_pin_eight_oe <= 1'b0;
    end else if (ce) begin
      output_pin_five_oe <= sink && (pin_sel_r == 2'h0);
      output_pin_six_oe <= sink && (pin_sel_r == 2'h1);
      output_pin_seven_oe <= sink && (pin_sel_r == 2'h2);
      output_pin_eight_oe <= sink && (pin_sel_r == 2'h3);
    end
  end

  // driven level is always ground; released pin floats to 12 V
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      output_pin_five <= 1'b0;
      output_pin_six <= 1'b0;
      output_pin_seven <= 1'b0;
      output_pin_eight <= 1'b0;
    end else if (ce) begin
      output_pin_five <= 1'b0;
      output_pin_six <= 1'b0;
      output_pin_seven <= 1'b0;
      output_pin_eight <= 1'b0;
    end
  end
endmodule // bsp_top
`default_nettype wire

// ---- hdl/bsp_regs.svh ----
// constants for the boost solenoid pwm output stage
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define BSP_CLK_MHZ 200
`define BSP_PERIOD_US_DEFAULT 33000
`define BSP_TICK_NS_NORMAL 1000
`define BSP_TICK_NS_SCALED 625
`define BSP_CLK_NS 5
// -------------------------------------------------------------
// duty format: tenths of a percent, 0..1000
// -------------------------------------------------------------
`define BSP_DUTY_FULL 10'd1000
`define BSP_CEIL_DEFAULT 10'd996
`define BSP_FLOOR_DEFAULT 10'd0
// -------------------------------------------------------------
// map shape
// -------------------------------------------------------------
`define BSP_MAP_COLS 21
`define BSP_MAP_ROWS 17
`define BSP_MAP_WORDS 357
`define BSP_RPM_MIN 16'd800
`define BSP_RPM_MAX 16'd8500
`define BSP_PIN_FIRST 3'd5
`define BSP_PIN_LAST 3'd0
`endif

// ---- hdl/bsp_pkg.sv ----
// types for the boost solenoid pwm output stage
package bsp_pkg;
  typedef logic [9:0] bsp_duty_t;
  typedef logic [8:0] bsp_addr_t;
  typedef enum logic [1:0] {
    BSP_PIN5,
    BSP_PIN6,
    BSP_PIN7,
    BSP_PIN8
  } bsp_pin_sel_t;
  typedef enum {
    BSP_ST_IDLE,
    BSP_ST_LOW,
    BSP_ST_HIGH
  } bsp_state_t;
endpackage

// ---- hdl/bsp_map_mem.sv ----
// duty map memory with registered read port
`timescale 1ns/100ps
`default_nettype none
`include "bsp_regs.svh"
module bsp_map_mem (
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic wr_en,
  input wire bsp_pkg::bsp_addr_t wr_addr,
  input wire bsp_pkg::bsp_duty_t wr_data,
  input wire bsp_pkg::bsp_addr_t rd_addr,
  output bsp_pkg::bsp_duty_t rd_data
);
  bsp_pkg::bsp_duty_t mem [0:`BSP_MAP_WORDS-1];

  always_ff @(posedge clk_sys) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // bsp_map_mem
`default_nettype wire

// ---- tb/bsp_coil_model.sv ----
// solenoid between switched supply and one sink pin
`timescale 1ns/100ps
`default_nettype none
module bsp_coil_model (
  input wire logic clk_sys,
  input wire logic [3:0] sink_oe,
  input wire logic [3:0] sink_drv,
  input wire logic [1:0] wired_pin,
  output logic [31:0] on_cnt
);
  logic [3:0] line;
  // a released pin floats up to the supply through the coil
  assign line = (sink_drv & sink_oe) | ~sink_oe;
  initial on_cnt = 32'h0;
  always @(posedge clk_sys) begin
    if (!line[wired_pin]) begin
      on_cnt <= on_cnt + 32'h1;
    end
  end
endmodule // bsp_coil_model
`default_nettype wire

// ---- tb/bsp_properties.sv ----
// assertions on the pins of the boost solenoid output stage
`timescale 1ns/100ps
`default_nettype none
module bsp_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] output_period_setting,
  input wire logic timebase_range_scaler,
  input wire logic [1:0] solenoid_output_select,
  input wire bsp_pkg::bsp_duty_t duty_ceiling,
  input wire bsp_pkg::bsp_duty_t duty_floor,
  input wire logic output_pin_five_oe,
  input wire logic output_pin_six_oe,
  input wire logic output_pin_seven_oe,
  input wire logic output_pin_eight_oe,
  input wire logic output_pin_five,
  input wire logic output_pin_six,
  input wire logic output_pin_seven,
  input wire logic output_pin_eight,
  input wire bsp_pkg::bsp_duty_t duty_applied,
  input wire logic period_start
);
  // -------------------------------------------------------------
  // config copy, taken once after reset like the design
  // -------------------------------------------------------------
  logic got_r, seen_r, scl_r;
  logic [1:0] sel_r;
  logic [15:0] per_r;
  logic [23:0] gap_r, run_r, tick, per_clk, low_clk;
  logic [3:0] oe;
  assign oe = {output_pin_eight_oe, output_pin_seven_oe,
    output_pin_six_oe, output_pin_five_oe};
  assign tick = scl_r ? 24'h7d : 24'hc8;
  // period zero not modelled: bench never sets it
  assign per_clk = 24'(per_r) * tick;
  assign low_clk = 24'(32'(per_r) * duty_applied / 32'h3e8) * tick;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      got_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= 24'h0;
      run_r <= 24'h0;
    end else begin
      got_r <= 1'b1;
      if (!got_r) begin
        per_r <= output_period_setting;
        scl_r <= timebase_range_scaler;
        sel_r <= solenoid_output_select;
      end
      seen_r <= seen_r | period_start;
      gap_r <= period_start ? 24'h1 : gap_r + 24'h1;
      run_r <= (|oe) ? run_r + 24'h1 : 24'h0;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  a_pins_sink_only:
    assert property (!(output_pin_five | output_pin_six | output_pin_seven
      | output_pin_eight)) else $error("pin driven high");
  a_single_pin:
    assert property ($onehot0(oe)) else $error("two pins sink");
  a_pin_from_select:
    assert property (got_r |-> (oe & ~(4'h1 << sel_r)) == 4'h0)
      else $error("wrong pin sinks");
  a_under_ceiling:
    assert property (period_start && duty_floor <= duty_ceiling |=>
      duty_applied <= $past(duty_ceiling)) else $error("over ceiling");
  a_over_floor:
    assert property (period_start |=> duty_applied >= $past(duty_floor))
      else $error("under floor");
  a_duty_at_edge:
    assert property ($changed(duty_applied) && !$past(period_start) |->
      ##[0:1] period_start) else $error("duty moved mid period");
  a_period_length:
    assert property (period_start && seen_r |-> gap_r == per_clk)
      else $error("wrong period");
  a_low_length:
    assert property ($fell(|oe) |-> run_r == low_clk)
      else $error("wrong low time");
  c_scaled: cover property (period_start && scl_r);
  c_low: cover property ($fell(|oe));
  c_pin_eight: cover property (output_pin_eight_oe);
endmodule // bsp_properties
bind bsp_top bsp_properties bsp_properties_inst (.clk_sys, .resetn,
  .output_period_setting, .timebase_range_scaler, .solenoid_output_select,
  .duty_ceiling, .duty_floor, .output_pin_five_oe, .output_pin_six_oe,
  .output_pin_seven_oe, .output_pin_eight_oe, .output_pin_five,
  .output_pin_six, .output_pin_seven, .output_pin_eight, .duty_applied,
  .period_start);
`default_nettype wire

// ---- tb/bsp_top_tb_top.sv ----
// self-checking bench of the boost solenoid output stage
`timescale 1ns/100ps
`default_nettype none
`include "bsp_regs.svh"
module bsp_top_tb_top;
  logic clk_sys, resetn, ce, scl, wr_en, use_sw, sw_pin, period_start;
  logic [15:0] per;
  logic [1:0] sel, wired;
  logic [4:0] rpm, load;
  logic [3:0] oe, drv;
  logic [31:0] on_cnt, snap;
  bsp_pkg::bsp_addr_t wa;
  bsp_pkg::bsp_duty_t wd, ceil_v, floor_v, lo_t, hi_t, duty_applied, prev;
  int error_cnt, compares, cur_per, cur_tick;
  bsp_top bsp_top_inst (.clk_sys, .resetn, .ce, .output_period_setting(per),
    .timebase_range_scaler(scl), .solenoid_output_select(sel),
    .duty_ceiling(ceil_v), .duty_floor(floor_v), .rpm_index(rpm),
    .load_index(load), .map_wr_en(wr_en), .map_wr_addr(wa),
    .map_wr_data(wd), .duty_low_target(lo_t), .duty_high_target(hi_t),
    .use_target_switch(use_sw), .target_switch_pin(sw_pin),
    .output_pin_five_oe(oe[0]), .output_pin_six_oe(oe[1]),
    .output_pin_seven_oe(oe[2]), .output_pin_eight_oe(oe[3]),
    .output_pin_five(drv[0]), .output_pin_six(drv[1]),
    .output_pin_seven(drv[2]), .output_pin_eight(drv[3]),
    .duty_applied, .period_start);
  bsp_coil_model bsp_coil_model_inst (.clk_sys, .sink_oe(oe),
    .sink_drv(drv), .wired_pin(wired), .on_cnt);
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic fail(input string m);
    error_cnt++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk_duty(input bsp_pkg::bsp_duty_t g, e);
    compares++;
    if (g !== e) fail("duty mismatch");
  endtask
  task automatic chk_cnt(input logic [31:0] g, e);
    compares++;
    if (g !== e) fail("on time mismatch");
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // polls on the falling edge so pulse values are settled
  task automatic wait_ps;
    int i;
    i = 0;
    @(negedge clk_sys);
    while (period_start !== 1'b1 && i < 4000) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 4000) fail("no period start");
  endtask
  task automatic do_reset(input logic [15:0] p, input logic s,
      input logic [1:0] l);
    @(posedge clk_sys);
    resetn <= 1'b0;
    per <= p;
    scl <= s;
    sel <= l;
    wired <= l;
    cur_per = p;
    cur_tick = s ? 125 : 200;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    wait_ps;
  endtask
  task automatic run(input logic [4:0] r, d, input bsp_pkg::bsp_duty_t c,
      f, input logic u, w, input bsp_pkg::bsp_duty_t e);
    @(posedge clk_sys);
    rpm <= r;
    load <= d;
    ceil_v <= c;
    floor_v <= f;
    use_sw <= u;
    sw_pin <= w;
    @(negedge clk_sys);
    chk_duty(duty_applied, prev);
    wait_ps;
    snap = on_cnt;
    @(negedge clk_sys);
    chk_duty(duty_applied, e);
    wait_ps;
    chk_cnt(on_cnt - snap, 32'(cur_per * e / 1000 * cur_tick));
    prev = e;
  endtask
  initial begin
    #400000;
    fail("watchdog expired");
    give_verdict;
  end
  initial begin
    {resetn, scl, sel, wired, rpm, load, wr_en, wa, wd} = '0;
    {ce, use_sw, sw_pin, per} = {1'b1, 1'b1, 1'b0, 16'h5};
    {ceil_v, floor_v, lo_t, hi_t} = {10'h3e4, 10'h0, 10'h190, 10'h3e7};
    {error_cnt, compares, prev} = {32'h0, 32'h0, 10'h190};
    do_reset(16'h5, 1'b0, 2'h0);
    // map is not reset, so fill it while the switch target drives
    for (int a = 0; a < `BSP_MAP_WORDS; a++) begin
      @(posedge clk_sys);
      wr_en <= 1'b1;
      wa <= 9'(a);
      wd <= 10'(a * 2 + 200);
    end
    @(posedge clk_sys);
    wr_en <= 1'b0;
    wait_ps;
    run(5'h3, 5'h2, 10'h3e4, 10'h0, 1'b0, 1'b0, 10'h122);
    run(5'h1f, 5'h1f, 10'h3e4, 10'h0, 1'b0, 1'b0, 10'h390);
    run(5'h1f, 5'h1f, 10'h12c, 10'h0, 1'b0, 1'b0, 10'h12c);
    run(5'h3, 5'h2, 10'h3e4, 10'h258, 1'b0, 1'b0, 10'h258);
    run(5'h0, 5'h0, 10'h1f4, 10'h2bc, 1'b0, 1'b0, 10'h2bc);
    run(5'h0, 5'h0, 10'h3e4, 10'h0, 1'b1, 1'b1, 10'h3e4);
    run(5'h0, 5'h0, 10'h3e4, 10'h0, 1'b1, 1'b0, 10'h190);
    @(posedge clk_sys);
    {per, scl, sel} <= {16'h9, 1'b1, 2'h3};
    run(5'h3, 5'h2, 10'h3e4, 10'h0, 1'b0, 1'b0, 10'h122);
    for (int k = 1; k < 4; k++) begin
      do_reset(16'(k + 1), 1'(k % 2), 2'(k));
      run(5'h1f, 5'h1f, 10'h3e4, 10'h0, 1'b0, 1'b0, 10'h390);
    end
    give_verdict;
  end
endmodule // bsp_top_tb_top
`default_nettype wire
